// >>> rtl/usfs_pkg.sv
// package of shared constants for the serial frame-format block, plus
// the baud and sample-tick generator that the block instantiates.
// assumes one clock, an asynchronous active-low reset, 32-bit Wishbone.
`timescale 1ns/100ps

package usfs_pkg;
   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [4:0] ADDR_MODE = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_BAUD = 5'h08;
   localparam logic [4:0] ADDR_TXDATA = 5'h0C;
   localparam logic [4:0] ADDR_RXDATA = 5'h10;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h14;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h18;

   // serial_mode_control fields
   localparam int MODE_ENABLE = 15;
   localparam int MODE_VOTE = 12;
   localparam int MODE_HS = 3;
   localparam int MODE_PW_HI = 2;
   localparam int MODE_PW_LO = 1;
   localparam int MODE_STOP = 0;
   localparam logic [15:0] MODE_MASK = 16'h900F;
   localparam logic [15:0] MODE_RESET = 16'h0000;

   // serial_status_control fields
   localparam int ST_TX_IRQ_HI = 15;
   localparam int ST_TX_POL = 14;
   localparam int ST_TX_IRQ_LO = 13;
   localparam int ST_TX_BRK = 11;
   localparam int ST_TX_EN = 10;
   localparam int ST_TX_FULL = 9;
   localparam int ST_TX_EMPTY = 8;
   localparam int ST_RX_IRQ_HI = 7;
   localparam int ST_RX_IRQ_LO = 6;
   localparam int ST_ADDR_DET = 5;
   localparam int ST_RX_IDLE = 4;
   localparam int ST_PARITY_ERROR_FLAG = 3;
   localparam int ST_FRAMING_ERROR_FLAG = 2;
   localparam int ST_OVERRUN_ERROR_FLAG = 1;
   localparam int ST_RXDA = 0;
   localparam logic [15:0] ST_CTRL_MASK = 16'hECE0;
   localparam logic [15:0] ST_CTRL_RESET = 16'h0000;

   localparam logic [15:0] BAUD_RESET = 16'h0000;

   // parity and width encodings
   localparam logic [1:0] PW_9N = 2'b11;
   localparam logic [1:0] PW_8O = 2'b10;
   localparam logic [1:0] PW_8E = 2'b01;
   localparam logic [1:0] PW_8N = 2'b00;

   // sampling
   localparam logic [4:0] SAMPLES_HS = 5'h04;
   localparam logic [4:0] SAMPLES_STD = 5'h10;
   localparam logic [4:0] MID_HS = 5'h02;
   localparam logic [4:0] MID_STD = 5'h08;
   localparam logic [4:0] MID_VOTE = 5'h09;

   // frame lengths in bits including start, before stop bits; the break length of 14 includes its stop bit
   localparam logic [3:0] FRAME_BASE_8 = 4'h9;
   localparam logic [3:0] FRAME_BASE_9 = 4'hA;
   localparam logic [3:0] FRAME_BREAK = 4'hE;
   localparam logic [3:0] RX_LAST_8N = 4'h9;
   localparam logic [3:0] RX_LAST_9 = 4'hA;

   // interrupt status bits
   localparam int IRQ_TX_DONE = 0;
   localparam int IRQ_RX_READY = 1;
   localparam int IRQ_RX_ERROR = 2;
   localparam int IRQ_W = 3;

   typedef enum logic {TX_IDLE, TX_SEND} usfs_tx_state_t;
   typedef enum logic {RX_IDLE, RX_BUSY} usfs_rx_state_t;
endpackage

module usfs_baud_gen #(
   parameter int DIV_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // configuration
   input wire logic [DIV_W-1:0] divider,
   input wire logic high_speed,
   input wire logic restart,
   // ticks
   output logic sample_tick,
   output logic bit_tick
);
   import usfs_pkg::*;

   logic [DIV_W-1:0] div_cnt;
   logic [4:0] sub_cnt;
   logic [4:0] seen;
   wire [4:0] samples_per_bit = high_speed ? SAMPLES_HS : SAMPLES_STD;
   wire sub_last = sub_cnt == samples_per_bit - 5'h01;

   // refused at elaboration: the down counter and its reload need 4..16 bits
   if (DIV_W < 4 || DIV_W > 16) begin : g_bad_div_w
      $error("DIV_W must be 4..16");
   end

   // divider+1 clocks per sample tick; free running so rx phase holds
   assign sample_tick = div_cnt == '0;
   assign bit_tick = sample_tick && sub_last && !restart;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= '0;
         sub_cnt <= 5'h00;
      end else begin
         div_cnt <= sample_tick ? divider : div_cnt - 1'b1;
         if (restart || (sample_tick && sub_last)) begin
            sub_cnt <= 5'h00;
         end else if (sample_tick) begin
            sub_cnt <= sub_cnt + 5'h01;
         end
      end
   end

   // helper: sample ticks since the last bit boundary
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seen <= 5'h00;
      end else if (restart || bit_tick) begin
         seen <= 5'h00;
      end else if (sample_tick) begin
         seen <= seen + 5'h01;
      end
   end

   a_bit_sample_count: assert property (@(posedge clk)
      disable iff (!reset_n)
      bit_tick && $stable(high_speed) |->
         seen == (high_speed ? 5'h03 : 5'h0F))
      else $error("bit period does not hold 4 or 16 sample ticks");
endmodule // usfs_baud_gen

// >>> rtl/usfs_port.sv
// serial port with configurable frame format and Wishbone registers.
// assumes a classic Wishbone master and a remote serial transceiver.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps

module usfs_port (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial pins
   output logic serial_tx_line,
   input wire logic serial_rx_line,
   // interrupt
   output logic irq
);
   import usfs_pkg::*;

   // ****************************************************************
   // registers and state
   // ****************************************************************
   logic [15:0] mode;
   logic [15:0] st_ctrl;
   logic [15:0] baud_divider;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [8:0] tx_hold;
   logic tx_buffer_full;
   usfs_tx_state_t tx_state;
   logic [13:0] tx_shift;
   logic [3:0] tx_left;
   usfs_rx_state_t rx_state;
   logic [4:0] rx_cnt;
   logic [3:0] rx_pos;
   logic [10:0] rx_frame;
   logic [1:0] rx_hist;
   logic [8:0] rx_data;
   logic parity_error_flag;
   logic framing_error_flag;
   logic overrun_error_flag;
   logic rx_data_available;

   function automatic logic [15:0] lane_write(input logic [15:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
      lane_write = {sel[1] ? dat[15:8] : old[15:8],
                    sel[0] ? dat[7:0] : old[7:0]};
   endfunction

   // ****************************************************************
   // bus decode
   // ****************************************************************
   wire req = wb_cyc_i && wb_stb_i;
   wire wr_now = req && wb_ack_o && wb_we_i;
   wire rd_now = req && wb_ack_o && !wb_we_i;
   wire wr_mode = wr_now && wb_adr_i == ADDR_MODE;
   wire wr_status = wr_now && wb_adr_i == ADDR_STATUS;
   wire wr_baud = wr_now && wb_adr_i == ADDR_BAUD;
   wire wr_txdata = wr_now && wb_adr_i == ADDR_TXDATA && wb_sel_i[0];
   wire wr_irq_stat = wr_now && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0];
   wire wr_irq_mask = wr_now && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0];
   wire rd_rxdata = rd_now && wb_adr_i == ADDR_RXDATA;
   wire clr_overrun_error_flag = wr_status && wb_sel_i[0] && !wb_dat_i[ST_OVERRUN_ERROR_FLAG];

   // configuration decode
   wire port_on = mode[MODE_ENABLE];
   wire high_speed_sample_select = mode[MODE_HS];
   wire [1:0] parity_width_select = mode[MODE_PW_HI:MODE_PW_LO];
   wire stop_count_select = mode[MODE_STOP];
   wire tx_idle_polarity = st_ctrl[ST_TX_POL];
   wire tx_break_request = st_ctrl[ST_TX_BRK];
   wire tx_enable_bit = st_ctrl[ST_TX_EN];
   wire tx_shift_empty = tx_state == TX_IDLE;
   wire rx_idle_flag = rx_state == RX_IDLE;

   wire [15:0] status_rd = (st_ctrl & ST_CTRL_MASK)
      | {6'h00, tx_buffer_full, tx_shift_empty, 3'h0, rx_idle_flag,
         parity_error_flag, framing_error_flag, overrun_error_flag,
         rx_data_available};

   logic [15:0] rd_mux;
   always_comb begin
      case (wb_adr_i)
         ADDR_MODE: rd_mux = mode;
         ADDR_STATUS: rd_mux = status_rd;
         ADDR_BAUD: rd_mux = baud_divider;
         ADDR_TXDATA: rd_mux = {7'h00, tx_hold};
         ADDR_RXDATA: rd_mux = {7'h00, rx_data};
         ADDR_IRQ_STAT: rd_mux = {13'h0000, irq_stat};
         ADDR_IRQ_MASK: rd_mux = {13'h0000, irq_mask};
         default: rd_mux = 16'h0000;
      endcase
   end

   // one wait state: ack in the cycle after the request is seen
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
         wb_dat_o <= {16'h0000, rd_mux};
      end
   end

   // ****************************************************************
   // baud generator
   // ****************************************************************
   logic sample_tick;
   logic bit_tick;
   wire brk_go = tx_shift_empty && port_on && tx_enable_bit
      && tx_break_request;
   wire tx_go = tx_shift_empty && port_on && tx_enable_bit
      && (tx_break_request || tx_buffer_full);

   usfs_baud_gen #(.DIV_W(16)) u_baud (
      .clk(clk),
      .reset_n(reset_n),
      .divider(baud_divider),
      .high_speed(high_speed_sample_select),
      .restart(tx_go),
      .sample_tick(sample_tick),
      .bit_tick(bit_tick)
   );

   // ****************************************************************
   // transmit framing
   // ****************************************************************
   wire tx_par = (parity_width_select == PW_8O) ? ~^tx_hold[7:0]
      : ^tx_hold[7:0];
   logic [13:0] frame_bits;
   logic [3:0] frame_len;
   always_comb begin
      case (parity_width_select)
         PW_9N: frame_bits = {4'hF, tx_hold, 1'b0};
         PW_8O, PW_8E: frame_bits = {4'hF, tx_par, tx_hold[7:0], 1'b0};
         default: frame_bits = {5'h1F, tx_hold[7:0], 1'b0};
      endcase
      frame_len = (parity_width_select == PW_8N ? FRAME_BASE_8
         : FRAME_BASE_9) + (stop_count_select ? 4'h2 : 4'h1);
      if (brk_go) begin
         frame_bits = {1'b1, 13'h0000};
         frame_len = FRAME_BREAK;
      end
   end

   wire tx_done = tx_state == TX_SEND && bit_tick && tx_left == 4'h1;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_state <= TX_IDLE;
         tx_shift <= 14'h3FFF;
         tx_left <= 4'h0;
      end else if (tx_go) begin
         tx_state <= TX_SEND;
         tx_shift <= frame_bits;
         tx_left <= frame_len;
      end else if (tx_state == TX_SEND && bit_tick) begin
         tx_shift <= {1'b1, tx_shift[13:1]};
         tx_left <= tx_left - 4'h1;
         if (tx_left == 4'h1) tx_state <= TX_IDLE;
      end
   end

   // line level is inverted when the idle polarity is 0
   wire tx_level = tx_state == TX_SEND ? tx_shift[0] : 1'b1;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) serial_tx_line <= 1'b0;
      else serial_tx_line <= tx_idle_polarity ? tx_level : !tx_level;
   end

   // ****************************************************************
   // receive framing
   // ****************************************************************
   // vote needs three samples around mid bit, too few at 4 per bit
   wire use_vote = mode[MODE_VOTE] && !high_speed_sample_select;
   wire vote = (serial_rx_line & rx_hist[1]) | (serial_rx_line & rx_hist[0])
      | (rx_hist[1] & rx_hist[0]);
   wire rx_bit = use_vote ? vote : serial_rx_line;
   wire [4:0] rx_spb = high_speed_sample_select ? SAMPLES_HS : SAMPLES_STD;
   wire [4:0] rx_point = use_vote ? MID_VOTE
      : (high_speed_sample_select ? MID_HS : MID_STD);
   wire [3:0] rx_last = parity_width_select == PW_8N ? RX_LAST_8N : RX_LAST_9;
   wire rx_at_point = rx_state == RX_BUSY && sample_tick && rx_cnt == rx_point;
   wire rx_false = rx_at_point && rx_pos == 4'h0 && rx_bit;
   wire rx_done = rx_at_point && rx_pos == rx_last;
   wire [8:0] rx_word = parity_width_select == PW_9N ? rx_frame[9:1]
      : {1'b0, rx_frame[8:1]};
   wire rx_parity_error_flag = (parity_width_select == PW_8E && ^rx_frame[9:1])
      || (parity_width_select == PW_8O && !(^rx_frame[9:1]));
   wire rx_overrun = rx_done && rx_data_available;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 5'h00;
         rx_pos <= 4'h0;
         rx_frame <= 11'h000;
         rx_hist <= 2'h3;
      end else begin
         if (sample_tick) rx_hist <= {rx_hist[0], serial_rx_line};
         if (rx_state == RX_IDLE) begin
            rx_cnt <= 5'h00;
            rx_pos <= 4'h0;
            if (sample_tick && port_on && !serial_rx_line) rx_state <= RX_BUSY;
         end else if (rx_false || rx_done || !port_on) begin
            rx_state <= RX_IDLE;
         end else if (sample_tick) begin
            if (rx_at_point) rx_frame[rx_pos] <= rx_bit;
            if (rx_cnt == rx_spb - 5'h01) begin
               rx_cnt <= 5'h00;
               rx_pos <= rx_pos + 4'h1;
            end else begin
               rx_cnt <= rx_cnt + 5'h01;
            end
         end
      end
   end

   // received word and flags; hardware set wins over software clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_data <= 9'h000;
         parity_error_flag <= 1'b0;
         framing_error_flag <= 1'b0;
         overrun_error_flag <= 1'b0;
         rx_data_available <= 1'b0;
      end else begin
         if (rx_done && !rx_data_available) begin
            rx_data <= rx_word;
            parity_error_flag <= rx_parity_error_flag;
            framing_error_flag <= !rx_bit;
         end
         if (rx_overrun) overrun_error_flag <= 1'b1;
         else if (clr_overrun_error_flag) overrun_error_flag <= 1'b0;
         if (rx_done) rx_data_available <= 1'b1;
         else if (rd_rxdata) rx_data_available <= 1'b0;
      end
   end

   // ****************************************************************
   // software registers and interrupt
   // ****************************************************************
   wire [IRQ_W-1:0] irq_ev = {rx_done && (rx_parity_error_flag || !rx_bit || rx_overrun),
      rx_done, tx_done};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode <= MODE_RESET;
         st_ctrl <= ST_CTRL_RESET;
         baud_divider <= BAUD_RESET;
         irq_stat <= '0;
         irq_mask <= '0;
         tx_hold <= 9'h000;
         tx_buffer_full <= 1'b0;
      end else begin
         if (wr_mode) mode <= lane_write(mode, wb_dat_i, wb_sel_i) & MODE_MASK;
         if (wr_status) begin
            st_ctrl <= lane_write(st_ctrl, wb_dat_i, wb_sel_i) & ST_CTRL_MASK;
         end else if (brk_go) begin
            st_ctrl[ST_TX_BRK] <= 1'b0;
         end
         if (wr_baud) baud_divider <= lane_write(baud_divider, wb_dat_i,
            wb_sel_i);
         irq_stat <= (irq_stat & ~(wr_irq_stat ? wb_dat_i[IRQ_W-1:0] : '0))
            | irq_ev;
         if (wr_irq_mask) irq_mask <= wb_dat_i[IRQ_W-1:0];
         // a write while full is dropped; break takes the line first
         if (wr_txdata && !tx_buffer_full) begin
            tx_hold <= {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]};
            tx_buffer_full <= 1'b1;
         end else if (tx_go && !brk_go) begin
            tx_buffer_full <= 1'b0;
         end
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ****************************************************************
   // checks
   // ****************************************************************
   a_nine_bit_len: assert property (@(posedge clk) disable iff (!reset_n)
      tx_go && !brk_go && parity_width_select == PW_9N |=>
         tx_left == FRAME_BASE_9 + ($past(stop_count_select) ? 4'h2 : 4'h1))
      else $error("nine-bit frame length wrong");
   a_odd_parity_bit: assert property (@(posedge clk) disable iff (!reset_n)
      tx_go && !brk_go && parity_width_select == PW_8O |=>
         tx_shift[9] == ~^tx_shift[8:1])
      else $error("odd parity bit wrong");
   a_even_parity_bit: assert property (@(posedge clk) disable iff (!reset_n)
      tx_go && !brk_go && parity_width_select == PW_8E |=>
         tx_shift[9] == ^tx_shift[8:1] && tx_left >= FRAME_BASE_9 + 4'h1)
      else $error("even parity bit wrong");
   a_no_parity_len: assert property (@(posedge clk) disable iff (!reset_n)
      tx_go && !brk_go && parity_width_select == PW_8N |=>
         tx_left == FRAME_BASE_8 + ($past(stop_count_select) ? 4'h2 : 4'h1))
      else $error("eight-bit no-parity frame length wrong");
   a_two_stop_bits: assert property (@(posedge clk) disable iff (!reset_n)
      tx_go && !brk_go && stop_count_select |=>
         tx_shift[tx_left - 4'h1] && tx_shift[tx_left - 4'h2]
         && !tx_shift[0])
      else $error("two stop bits missing");
   a_vote_std_only: assert property (@(posedge clk) disable iff (!reset_n)
      use_vote |-> !high_speed_sample_select && rx_point == MID_VOTE)
      else $error("vote used outside sixteen-sample mode");
   a_idle_tx_level: assert property (@(posedge clk) disable iff (!reset_n)
      tx_state == TX_IDLE ##1 tx_state == TX_IDLE &&
         $stable(tx_idle_polarity) |=> serial_tx_line == $past(tx_idle_polarity))
      else $error("tx idle level does not follow polarity");
   a_overrun_sticky: assert property (@(posedge clk) disable iff (!reset_n)
      overrun_error_flag && !clr_overrun_error_flag |=> overrun_error_flag)
      else $error("overrun cleared without software");

   c_tx_frame: cover property (@(posedge clk) disable iff (!reset_n)
      tx_done);
   c_rx_error: cover property (@(posedge clk) disable iff (!reset_n)
      rx_done && rx_parity_error_flag);
   c_break_sent: cover property (@(posedge clk) disable iff (!reset_n)
      brk_go);
   c_overrun: cover property (@(posedge clk) disable iff (!reset_n)
      rx_overrun);
endmodule // usfs_port

// >>> verification/usfs_remote_model.sv
// remote serial transceiver: captures frames from the port, sends frames.
// assumes the line idles high and the bench sets the bit time in clocks.
`timescale 1ns/100ps

module usfs_remote_model (
   // clock
   input wire logic clk,
   // serial lines
   input wire logic line_in,
   output logic line_out
);
   int bit_clks = 32;
   logic [15:0] cap;

   // mid-bit sampling, timed from the falling start edge
   task automatic capture(input int n);
      cap = 16'h0000;
      while (line_in !== 1'b0) @(posedge clk);
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         cap[i] = line_in;
         repeat (bit_clks) @(posedge clk);
      end
   endtask

   // bits go out LSB first; line returns to idle high afterwards
   task automatic send(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         line_out <= bits[i];
         repeat (bit_clks) @(posedge clk);
      end
      line_out <= 1'b1;
      // one edge of idle so that a following send never reassigns the line
      @(posedge clk);
   endtask

   initial line_out = 1'b1;
endmodule // usfs_remote_model

// >>> verification/uart_frame_format_and_status_tb.sv
// self-checking bench for the serial frame-format port.
// assumes the remote model on the serial pins and a 40 MHz clock.
`timescale 1ns/100ps

module uart_frame_format_and_status_tb;
   import usfs_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [4:0] wb_adr = 5'h00;
   logic [31:0] wb_dat = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic tx_line;
   logic rx_line;
   logic irq;
   int bad_count = 0;
   int samples_checked = 0;
   logic [15:0] rd;
   logic [15:0] fr;
   int n;
   logic [1:0] pw;
   logic st, hs, vt;
   logic [8:0] d1, d2;

   always #12.5 clk = ~clk;

   usfs_port uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .serial_tx_line(tx_line),
      .serial_rx_line(rx_line), .irq(irq));
   usfs_remote_model m (.clk(clk), .line_in(tx_line), .line_out(rx_line));

   // ****************************************************************
   // tasks and functions
   // ****************************************************************
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // entered just after a rising edge; one idle cycle follows each access
   task automatic wb(input logic [4:0] a, input logic w,
      input logic [15:0] d);
      int k;
      k = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= {16'h0000, d};
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      if (wb_ack_o !== 1'b1) bad_count++;
      rd = wb_dat_o[15:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_bit(input int b, input logic v);
      int k;
      k = 0;
      do begin
         wb(ADDR_STATUS, 1'b0, 16'h0000);
         k++;
      end while (rd[b] !== v && k < 400);
      check("status bit", {15'h0000, v}, {15'h0000, rd[b]});
   endtask

   // expected line bits: start, data LSB first, parity, stops, idle ones
   function automatic logic [15:0] frame(input logic [8:0] d,
      input logic [1:0] p, input logic s, output int len);
      logic [15:0] f;
      f = 16'hFFFF;
      f[0] = 1'b0;
      f[8:1] = d[7:0];
      len = 9;
      if (p == PW_9N) begin
         f[9] = d[8];
         len = 10;
      end else if (p != PW_8N) begin
         f[9] = (p == PW_8O) ? ~^d[7:0] : ^d[7:0];
         len = 10;
      end
      len = len + 1 + int'(s);
      return f;
   endfunction

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      print_verdict();
   end

   initial begin
      void'($urandom(49));
      repeat (20) @(posedge clk);
      check("tx idle in reset", 16'h0000, {15'h0000, tx_line});
      reset_n <= 1'b1;
      @(posedge clk);
      wb(ADDR_STATUS, 1'b0, 16'h0000);
      check("status reset", 16'h0110, rd);
      wb(5'h1C, 1'b0, 16'h0000);
      check("unmapped read", 16'h0000, rd);
      wb(ADDR_BAUD, 1'b1, 16'h0001);
      wb(ADDR_STATUS, 1'b1, 16'h4400);
      // the line is registered: one more edge before it shows the new level
      @(posedge clk);
      check("tx idle high", 16'h0001, {15'h0000, tx_line});
      wb(ADDR_STATUS, 1'b1, 16'h0400);
      @(posedge clk);
      check("tx idle low", 16'h0000, {15'h0000, tx_line});
      wb(ADDR_STATUS, 1'b1, 16'h4400);
      for (int i = 0; i < 16; i++) begin
         pw = i[1:0];
         st = i[2];
         hs = i[3];
         vt = 1'($urandom);
         d1 = 9'($urandom);
         d2 = 9'($urandom);
         m.bit_clks = hs ? 8 : 32;
         wb(ADDR_MODE, 1'b1, {3'b100, vt, 8'h00, hs, pw, st});
         fr = frame(d1, pw, st, n);
         fr[n] = 1'b0;
         fork
            m.capture(n + 1);
            begin
               wb(ADDR_TXDATA, 1'b1, {7'h00, d1});
               wait_bit(ST_TX_FULL, 1'b0);
               wb(ADDR_TXDATA, 1'b1, {7'h00, d2});
            end
         join
         fr = fr & ((16'h0001 << (n + 1)) - 16'h0001);
         check("tx frame", fr, m.cap);
         wait_bit(ST_TX_EMPTY, 1'b1);
         fr = frame(d1, pw, st, n);
         m.send(fr, n);
         wait_bit(ST_RXDA, 1'b1);
         check("rx parity ok", 16'h0000, {15'h0000, rd[ST_PARITY_ERROR_FLAG]});
         wb(ADDR_RXDATA, 1'b0, 16'h0000);
         check("rx data", {7'h00, pw == PW_9N && d1[8], d1[7:0]}, rd);
         if (pw == PW_8O || pw == PW_8E) begin
            fr[9] = ~fr[9];
            m.send(fr, n);
            wait_bit(ST_RXDA, 1'b1);
            check("rx parity bad", 16'h0001, {15'h0000, rd[ST_PARITY_ERROR_FLAG]});
            wb(ADDR_RXDATA, 1'b0, 16'h0000);
         end
      end
      // break: start, twelve zeros, one stop; the request clears itself
      fork
         m.capture(14);
         wb(ADDR_STATUS, 1'b1, 16'h4C00);
      join
      check("break frame", 16'h2000, m.cap);
      wait_bit(ST_TX_EMPTY, 1'b1);
      check("break request cleared", 16'h0000, {15'h0000, rd[ST_TX_BRK]});
      // overrun: two frames unread, then a software clear
      m.send(fr, n);
      m.send(fr, n);
      wait_bit(ST_OVERRUN_ERROR_FLAG, 1'b1);
      wb(ADDR_RXDATA, 1'b0, 16'h0000);
      wb(ADDR_STATUS, 1'b1, 16'h4400);
      wb(ADDR_STATUS, 1'b0, 16'h0000);
      check("overrun cleared", 16'h0000, {15'h0000, rd[ST_OVERRUN_ERROR_FLAG]});
      check("irq masked", 16'h0000, {15'h0000, irq});
      wb(ADDR_IRQ_MASK, 1'b1, 16'h0002);
      check("irq raised", 16'h0001, {15'h0000, irq});
      wb(ADDR_IRQ_STAT, 1'b1, 16'h0002);
      check("irq cleared", 16'h0000, {15'h0000, irq});
      m.send(fr, n);
      wait_bit(ST_RXDA, 1'b1);
      check("irq on rx", 16'h0001, {15'h0000, irq});
      print_verdict();
   end
endmodule // uart_frame_format_and_status_tb
